// ---- iomir_defs.svh ----
`ifndef IOMIR_DEFS_SVH
`define IOMIR_DEFS_SVH

// source count: eight terminals plus logging-complete
`define IOMIR_NUM_SRC 9
`define IOMIR_NUM_TERM 8
// logging buffer depth that raises the logging-complete event
`define IOMIR_LOG_POINTS 5120
// request slot periods in ns and the clock period in ns
`define IOMIR_CLK_NS 10
`define IOMIR_SLOT_FAST_NS 50000
`define IOMIR_SLOT_SLOW_NS 100000
`define IOMIR_RESP_MAX_NS 200000
`define IOMIR_SLOT_FAST_CYC (`IOMIR_SLOT_FAST_NS / `IOMIR_CLK_NS)
`define IOMIR_SLOT_SLOW_CYC (`IOMIR_SLOT_SLOW_NS / `IOMIR_CLK_NS)
`define IOMIR_VEC_W 10
`define IOMIR_VEC_NONE 10'h000

`endif

// ---- iomir_pkg.sv ----
package iomir_pkg;
    `include "iomir_defs.svh"

    // one entry of the interrupt setting table
    typedef struct packed {
        logic valid;
        logic [`IOMIR_VEC_W-1:0] vector;
    } iomir_vec_cfg_t;

    // request handed to the host
    typedef struct packed {
        logic valid;
        logic [3:0] number;
        logic [`IOMIR_VEC_W-1:0] vector;
    } iomir_req_t;

    typedef enum logic [1:0] {
        IOMIR_IDLE,
        IOMIR_EMIT,
        IOMIR_GAP
    } iomir_state_t;
endpackage : iomir_pkg

// ---- iomir_rate_div.sv ----
`timescale 1ns/10ps
// slot enable divider: one pulse per selected period
module iomir_rate_div #(
    parameter int FAST_CYC = 5000,
    parameter int SLOW_CYC = 10000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    output logic tick_o
);
    logic [16:0] cnt_r;
    logic [16:0] cnt_nxt;
    wire [16:0] limit = slow_i ? 17'(SLOW_CYC - 1) : 17'(FAST_CYC - 1);
    wire at_end = (cnt_r >= limit);

    assign cnt_nxt = at_end ? 17'h00000 : cnt_r + 17'h00001;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 17'h00000;
            tick_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_o <= at_end;
        end
    end

    // no two slot ticks in a row while the fast period is selected
    tick_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o && !slow_i |=> !tick_o) else $error("slot ticks too close");
endmodule : iomir_rate_div

// ---- iomir_core.sv ----
`timescale 1ns/10ps
// Summary of operation
// - a source terminal going high (rising edge) raises a request to the host
// - logging buffer reaching 5120 points raises a request
// - at most nine vectors exist per device
// - counter event or compare outputs drive the source terminals
// - terminals 0..7 and logging map to numbers 1..9, each with a vector
// - sources without a configured vector never request
// - logging request also needs the logging interrupt enable
// - a source firing again later requests again, no acknowledge needed
// - requests leave on a 50 us slot; repeats within a slot are dropped
// - slot becomes 100 us in synchronized high-speed mode or conversion logging
// - response latency stays within 200 us while logging runs
// - vector settings apply only after they are written in
module iomir_core
    import iomir_pkg::*;
#(
    parameter int NSRC = `IOMIR_NUM_SRC,
    parameter int NTERM = `IOMIR_NUM_TERM,
    parameter int LOG_POINTS = `IOMIR_LOG_POINTS,
    parameter int FAST_CYC = `IOMIR_SLOT_FAST_CYC,
    parameter int SLOW_CYC = `IOMIR_SLOT_SLOW_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [NTERM-1:0] cnt_match_i,
    input wire logic [NTERM-1:0] cnt_event_i,
    input wire logic log_store_i,
    input wire logic log_restart_i,
    input wire logic log_irq_en_i,
    input wire logic sync_hs_mode_i,
    input wire logic adc_log_active_i,
    input wire logic cfg_write_i,
    input wire logic [3:0] cfg_index_i,
    input wire iomir_vec_cfg_t cfg_data_i,
    output iomir_req_t req_o,
    output logic [NTERM-1:0] term_o,
    output logic log_done_o,
    output logic [NSRC-1:0] pending_o
);
    ////////////////////////////////////////////////////////////////////////
    // configuration table, loaded only by explicit writes
    iomir_vec_cfg_t vec_r [NSRC];
    wire cfg_hit = cfg_write_i && (cfg_index_i >= 4'h1) && (cfg_index_i <= 4'(NSRC));
    wire [3:0] cfg_slot = cfg_index_i - 4'h1;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NSRC; i++) vec_r[i] <= '0;
        end else if (cfg_hit) begin
            vec_r[cfg_slot] <= cfg_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source terminals and logging counter
    logic [NTERM-1:0] term_prev_r;
    logic [12:0] log_cnt_r;
    logic [12:0] log_cnt_nxt;
    logic log_fire;
    wire [NTERM-1:0] term_lvl = cnt_match_i | cnt_event_i;
    // rising high on a terminal is an event
    wire [NTERM-1:0] term_rise = term_lvl & ~term_prev_r;
    // fill point of the logging area
    assign log_fire = log_store_i && (log_cnt_r == 13'(LOG_POINTS - 1));
    assign log_cnt_nxt = log_restart_i ? 13'h0000 :
        log_fire ? 13'h0000 : (log_store_i ? log_cnt_r + 13'h0001 : log_cnt_r);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            term_prev_r <= '0;
            log_cnt_r <= 13'h0000;
            term_o <= '0;
            log_done_o <= 1'b0;
        end else begin
            term_prev_r <= term_lvl;
            log_cnt_r <= log_cnt_nxt;
            term_o <= term_lvl;
            log_done_o <= log_fire && !log_restart_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gating by vector and enable
    logic [NSRC-1:0] src_evt;
    logic [NSRC-1:0] src_ok;
    // source order is terminals first, logging last
    assign src_evt = {log_fire && !log_restart_i, term_rise};
    // vector must be set; logging also needs its enable
    always_comb begin
        src_ok = '0;
        for (int i = 0; i < NSRC; i++) src_ok[i] = vec_r[i].valid;
        src_ok[NSRC-1] = vec_r[NSRC-1].valid && log_irq_en_i;
    end
    wire [NSRC-1:0] src_take = src_evt & src_ok;

    ////////////////////////////////////////////////////////////////////////
    // slot timing
    logic tick;
    wire slow_sel = sync_hs_mode_i || adc_log_active_i;
    iomir_rate_div #(
        .FAST_CYC(FAST_CYC),
        .SLOW_CYC(SLOW_CYC)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .slow_i(slow_sel),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // pending flags and request emission
    logic [NSRC-1:0] pend_r;
    logic [NSRC-1:0] pend_nxt;
    logic [NSRC-1:0] emit_mask;
    logic [3:0] emit_idx;
    // lowest pending terminal leaves first in each slot
    always_comb begin
        emit_mask = '0;
        emit_idx = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend_r[i]) begin
                emit_mask = '0;
                emit_mask[i] = 1'b1;
                emit_idx = 4'(i);
            end
        end
        // logging jumps the queue
        // keeps its wait within one slow slot even with all terminals pending
        if (pend_r[NSRC-1]) begin
            emit_mask = '0;
            emit_mask[NSRC-1] = 1'b1;
            emit_idx = 4'(NSRC - 1);
        end
    end
    wire emit = tick && (|pend_r);
    // set wins over clear; repeats fold into one flag
    assign pend_nxt = (pend_r & ~(emit ? emit_mask : '0)) | src_take;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r <= '0;
            pending_o <= '0;
        end else begin
            pend_r <= pend_nxt;
            pending_o <= pend_nxt;
        end
    end

    // cycles the logging request has waited
    localparam int RESP_CYC = 2 * SLOW_CYC;
    logic [15:0] log_wait_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            log_wait_r <= 16'h0000;
        end else if (!pend_r[NSRC-1]) begin
            log_wait_r <= 16'h0000;
        end else if (log_wait_r != 16'hFFFF) begin
            log_wait_r <= log_wait_r + 16'h0001;
        end
    end

    // one request per slot, number 1..9, no acknowledge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_o <= '0;
        end else begin
            req_o.valid <= emit;
            req_o.number <= emit ? emit_idx + 4'h1 : 4'h0;
            req_o.vector <= emit ? vec_r[emit_idx].vector : `IOMIR_VEC_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    rise_pend_a: assert property (@(posedge clk_i) disable iff (rst_i)
        term_rise[0] && vec_r[0].valid |=> pend_r[0]) else $error("terminal 0 lost");
    no_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
        src_evt[0] && !vec_r[0].valid && !pend_r[0] |=> !pend_r[0]) else $error("unset vec");
    log_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        log_fire && !log_irq_en_i && !pend_r[NSRC-1] |=> !pend_r[NSRC-1])
        else $error("log gate");
    req_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_o.valid |-> $past(tick)) else $error("request off slot");
    emit_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        emit && !src_take[emit_idx] |=> !pend_r[$past(emit_idx)]) else $error("flag kept");
    num_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_o.valid |-> req_o.number >= 4'h1 && req_o.number <= 4'h9) else $error("bad number");
    refire_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_o.valid ##1 (src_take[0] && !pend_r[0]) |=> pend_r[0]) else $error("refire lost");
    log_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        log_fire && !log_restart_i |=> log_done_o && log_cnt_r == 13'h0000) else $error("log fill");
    sequence log_at_tick_s;
        tick && pend_r[NSRC-1];
    endsequence
    sequence log_req_s;
        req_o.valid && req_o.number == 4'(NSRC);
    endsequence
    log_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        log_at_tick_s |=> log_req_s) else $error("logging not first");
    log_resp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        log_wait_r < 16'(RESP_CYC)) else $error("logging wait too long");
    req_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_o.valid |=> !req_o.valid) else $error("request held");
    cfg_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_hit |=> vec_r[$past(cfg_slot)] == $past(cfg_data_i)) else $error("cfg lost");
endmodule : iomir_core

// ---- iomir_host.sv ----
`timescale 1ns/10ps
// host side: takes every request and keeps the last one it serviced
module iomir_host
    import iomir_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire iomir_req_t req_i,
    output int served_o,
    output iomir_req_t last_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            served_o <= 0;
            last_o <= '0;
        end else if (req_i.valid) begin
            served_o <= served_o + 1;
            last_o <= req_i;
        end
    end
endmodule : iomir_host

// ---- io_module_interrupt_requester_test.sv ----
`timescale 1ns/10ps
module io_module_interrupt_requester_test;
    import iomir_pkg::*;
    localparam int F = 20;
    localparam int S = 40;
    logic clk = 0, rst = 1, store = 0, restart = 0, log_en = 0, hs = 0, adc = 0, cfg_wr = 0;
    logic [7:0] match = '0, evt = '0, term;
    logic [3:0] cfg_idx = '0;
    logic [8:0] pend;
    logic done;
    iomir_vec_cfg_t cfg_d = '0;
    iomir_req_t req, last;
    int bad_count = 0, tests_run = 0, cyc = 0, served, n0;

    iomir_core #(.FAST_CYC(F), .SLOW_CYC(S), .LOG_POINTS(8)) DUT (.clk_i(clk), .rst_i(rst),
        .cnt_match_i(match), .cnt_event_i(evt), .log_store_i(store), .log_restart_i(restart),
        .log_irq_en_i(log_en), .sync_hs_mode_i(hs), .adc_log_active_i(adc), .cfg_write_i(cfg_wr),
        .cfg_index_i(cfg_idx), .cfg_data_i(cfg_d), .req_o(req), .term_o(term),
        .log_done_o(done), .pending_o(pend));
    iomir_host host (.clk_i(clk), .rst_i(rst), .req_i(req), .served_o(served), .last_o(last));

    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task fire(input int i, input bit ev);
        // sources idle low, no zero-compare start
        @(posedge clk);
        if (ev) evt[i] <= 1'b1;
        else match[i] <= 1'b1;
        @(posedge clk);
        evt <= '0;
        match <= '0;
    endtask : fire
    task cfg(input int i, input logic [9:0] v);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_idx <= 4'(i);
        cfg_d <= '{1'b1, v};
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask : cfg
    task wait_req(input int n, input logic [9:0] v);
        int k;
        k = 0;
        do begin
            tick(1);
            k++;
        end while (req.valid !== 1'b1 && k < 3 * S);
        check(req, {1'b1, 4'(n), v});
    endtask : wait_req
    ////////////////////////////////////////////////////////////////////////
    task t_unset;
        fire(0, 0);
        n0 = served;
        tick(3 * F);
        check(served, n0);
        $display("t_unset done");
    endtask : t_unset
    task t_terms;
        for (int i = 0; i < 8; i++) cfg(i + 1, 10'h0A0 + 10'(i));
        for (int i = 0; i < 8; i++) begin
            fire(i, i[0]);
            #1;
            check(term, 8'h01 << i);
            wait_req(i + 1, 10'h0A0 + 10'(i));
        end
        $display("t_terms done");
    endtask : t_terms
    task t_merge;
        fire(1, 0);
        wait_req(2, 10'h0A1);
        fire(0, 0);
        #1;
        check(pend[0], 1);
        fire(0, 1);
        n0 = served;
        tick(2 * F);
        check(served, n0 + 1);
        check(pend[0], 0);
        fire(0, 0);
        wait_req(1, 10'h0A0);
        $display("t_merge done");
    endtask : t_merge
    task t_log;
        cfg(9, 10'h0B9);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            log_en <= p[0];
            restart <= 1'b1;
            @(posedge clk);
            restart <= 1'b0;
            repeat (8) begin
                @(posedge clk) store <= 1'b1;
                @(posedge clk) store <= 1'b0;
            end
            #1;
            check(done, 1);
            n0 = served;
            tick(3 * F);
            check(served - n0, p);
            if (p == 1) check(last, {1'b1, 4'h9, 10'h0B9});
        end
        $display("t_log done");
    endtask : t_log
    task t_slow;
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            hs <= (m == 0);
            adc <= (m == 1);
            match[2:1] <= 2'h3;
            @(posedge clk);
            match <= '0;
            wait_req(2, 10'h0A1);
            n0 = cyc;
            wait_req(3, 10'h0A2);
            check(cyc - n0, S);
        end
        @(posedge clk);
        hs <= 1'b0;
        adc <= 1'b0;
        $display("t_slow done");
    endtask : t_slow
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_unset();
        t_terms();
        t_merge();
        t_log();
        t_slow();
        finish_test();
    end
endmodule : io_module_interrupt_requester_test
